//--- hdl/sas_params.svh
// Offsets, field positions, reset values and timing counts of the converter sequencer
`ifndef SAS_PARAMS_SVH
`define SAS_PARAMS_SVH
// ****************************************
// Register offsets (byte index on the plain port)
// ****************************************
`define SAS_OFF_CTRL_A   3'h0
`define SAS_OFF_CTRL_B   3'h1
`define SAS_OFF_UPCFG    3'h2
`define SAS_OFF_RES_HI   3'h3
`define SAS_OFF_RES_LO   3'h4
`define SAS_OFF_FLAGS    3'h5
// ****************************************
// Field positions and reset values
// ****************************************
`define SAS_BIT_ON       0
`define SAS_BIT_GO       1
`define SAS_BIT_DONE     0
`define SAS_BIT_IRQEN    1
`define SAS_RST_CTRL_A   8'h00
`define SAS_RST_CTRL_B   8'h00
`define SAS_RST_UPCFG    8'h00
`define SAS_UPCFG_MASK   8'hfc
`define SAS_UPCFG_MASK64 8'h0c
// ****************************************
// Timing counts in conversion periods and system clocks
// ****************************************
`define SAS_CONV_TADS    4'ha
`define SAS_WAIT_TADS    2'h2
`define SAS_DIV_2        6'h01
`define SAS_DIV_4        6'h03
`define SAS_DIV_8        6'h07
`define SAS_DIV_16       6'h0f
`define SAS_DIV_32       6'h1f
`define SAS_DIV_64       6'h3f
`endif

//--- hdl/sas_pkg.sv
// Types shared by the converter sequencer modules
package sas_pkg;
  // ****************************************
  // Register layouts
  // ****************************************
  typedef struct packed {
    logic       vref_neg_ext;
    logic       vref_pos_ext;
    logic [3:0] channel;
    logic       go;
    logic       converter_on;
  } sas_ctrl_a_t;

  typedef struct packed {
    logic       right_justify;
    logic       calibrate;
    logic [2:0] acquisition_time_sel;
    logic [2:0] conversion_clock_sel;
  } sas_ctrl_b_t;

  // ****************************************
  // Analog front-end controls
  // ****************************************
  typedef struct packed {
    logic       hold_connect;
    logic       vref_pos_ext;
    logic       vref_neg_ext;
    logic [3:0] channel;
    logic [9:0] trial_code;
  } sas_analog_t;

  typedef enum logic [1:0] {
    SAS_SAMPLE = 2'b00,
    SAS_ACQ    = 2'b01,
    SAS_CONV   = 2'b10,
    SAS_WAIT   = 2'b11
  } sas_state_t;
endpackage

//--- hdl/sas_tad_gen.sv
// Conversion period tick generator: system clock divider or synchronised RC oscillator
`timescale 1ns/1ns
`default_nettype none
`include "sas_params.svh"
module sas_tad_gen (
  input  wire logic       clk_in,     // System clock
  input  wire logic       rst_in,     // Async reset, active high
  input  wire logic       enable_in,  // Converter on
  input  wire logic [2:0] sel_in,     // Conversion clock select
  input  wire logic       rc_osc_in,  // RC oscillator pin, async
  input  wire logic       sleep_in,   // Synchronised sleep level
  output logic            tick_out    // One pulse per conversion period
);
  logic [5:0] div_reg;
  logic [5:0] lim;
  logic       rc_s1_reg;
  logic       rc_s2_reg;
  logic       rc_s3_reg;
  logic       is_rc;

  assign is_rc = (sel_in[1:0] == 2'b11);

  always_comb begin
    unique case (sel_in)
      3'b000:  lim = `SAS_DIV_2;
      3'b001:  lim = `SAS_DIV_8;
      3'b010:  lim = `SAS_DIV_32;
      3'b100:  lim = `SAS_DIV_4;
      3'b101:  lim = `SAS_DIV_16;
      3'b110:  lim = `SAS_DIV_64;
      default: lim = `SAS_DIV_2;
    endcase
  end

  // Oscillator is foreign to clk_in, so it crosses two flops before the edge detector
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rc_s1_reg <= 1'b0;
      rc_s2_reg <= 1'b0;
      rc_s3_reg <= 1'b0;
    end else begin
      rc_s1_reg <= rc_osc_in;
      rc_s2_reg <= rc_s1_reg;
      rc_s3_reg <= rc_s2_reg;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      div_reg  <= 6'h00;
      tick_out <= 1'b0;
    end else if (!enable_in) begin
      div_reg  <= 6'h00;
      tick_out <= 1'b0;
    end else if (is_rc) begin
      div_reg  <= 6'h00;
      tick_out <= rc_s2_reg & ~rc_s3_reg;
    end else begin
      div_reg  <= (div_reg >= lim) ? 6'h00 : div_reg + 6'h01;
      tick_out <= (div_reg >= lim) && !sleep_in;
    end
  end

  sleep_stall_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (sleep_in && !is_rc) |=> !tick_out)
    else $error("conversion period ticked in sleep without RC clock");
endmodule
`default_nettype wire

//--- hdl/sas_sar_core.sv
// Successive approximation register: ten bit decisions plus one closing period
`timescale 1ns/1ns
`default_nettype none
`include "sas_params.svh"
module sas_sar_core (
  input  wire logic       clk_in,    // System clock
  input  wire logic       rst_in,    // Async reset, active high
  input  wire logic       start_in,  // Begin conversion
  input  wire logic       abort_in,  // Drop conversion
  input  wire logic       tick_in,   // Conversion period tick
  input  wire logic       comp_in,   // Comparator on clk_in timing, 1 = input at or above trial
  output logic [9:0]      code_out,  // Trial code, final result when done
  output logic            done_out,  // One-cycle completion pulse
  output logic [3:0]      step_out   // Periods elapsed in this conversion
);
  logic busy_reg;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_reg <= 1'b0;
      code_out <= 10'h000;
      done_out <= 1'b0;
      step_out <= 4'h0;
    end else begin
      done_out <= 1'b0;
      if (abort_in) begin
        busy_reg <= 1'b0;
      end else if (start_in) begin
        busy_reg <= 1'b1;
        code_out <= 10'h200;
        step_out <= 4'h0;
      end else if (busy_reg && tick_in) begin
        if (step_out == `SAS_CONV_TADS) begin
          busy_reg <= 1'b0;
          done_out <= 1'b1;
        end else begin
          // Keep or drop the bit under trial, then try the next lower one
          code_out[4'd9 - step_out] <= comp_in;
          if (step_out != 4'd9) begin
            code_out[4'd8 - step_out] <= 1'b1;
          end
          step_out <= step_out + 4'h1;
        end
      end
    end
  end
endmodule
`default_nettype wire

//--- hdl/sas_sequencer.sv
// Converter sequencer top: registers, acquisition and conversion control, pin configuration
// What this block does
// - Upper config bits 7:2 set to one make their pins digital.
// - Config bit zero: pin analog, digital input off, digital read zero.
// - Config bits 1:0 ignore writes and read zero.
// - Channels fifteen to twelve exist only on the larger variant.
// - Software picks supply rails or external pins as references.
// - Conversion in sleep only runs on the RC conversion clock.
// - Result comes by successive approximation of the held sample.
// - Completion loads result pair, clears start bit, sets done flag.
// - Reset restores registers, switches off, aborts any conversion.
// - Reset leaves the result pair untouched.
// - Acquisition code zero: start bit converts at once.
// - Nonzero acquisition code samples 2 to 20 periods as listed below, then converts.
// - After a conversion sampling of the selected channel resumes.
// - Only the start bit shows activity; acquisition and conversion look alike.
// - Two conversion periods pass after a conversion before acquisition restarts.
// - Holding capacitor is cut off from the pin throughout conversion.
// - Each conversion yields a 10-bit code, 1024 steps.
// - Acquisition codes give 0,2,4,6,8,12,16,20 conversion periods.
// - Clock codes give divide by 2,8,32,4,16,64 or RC.
// - A conversion takes eleven conversion periods.
// - Clearing the start bit mid-conversion aborts, result kept.
`timescale 1ns/1ns
`default_nettype none
`include "sas_params.svh"
module sas_sequencer #(
  parameter bit PINS80 = 1'b1                     // Larger package variant
) (
  input  wire logic                 clk_in,       // System clock, 10 MHz
  input  wire logic                 rst_in,       // Async reset, active high
  input  wire logic [2:0]           addr_in,      // Register address
  input  wire logic [7:0]           wdata_in,     // Write data
  input  wire logic                 wr_in,        // Write strobe
  input  wire logic                 rd_in,        // Read strobe
  output logic [7:0]                rdata_out,    // Read data, cycle after strobe
  input  wire logic                 rc_osc_in,    // RC conversion oscillator
  input  wire logic                 sleep_in,     // Device in sleep, async
  input  wire logic                 comp_in,      // Comparator result, follows trial code on clk_in
  input  wire logic [5:0]           pin_din_in,   // Digital levels of upper pins
  output logic [5:0]                pin_dig_out,  // Digital reads of upper pins
  output logic [5:0]                pin_ana_out,  // Upper pins in analog mode
  output sas_pkg::sas_analog_t      analog_out,   // Front-end controls
  output logic                      done_flag_out,// Conversion done flag
  output logic                      irq_en_out    // Conversion interrupt enable
);
  // ****************************************
  // Declarations
  // ****************************************
  sas_pkg::sas_ctrl_a_t ctrl_a_reg;
  sas_pkg::sas_ctrl_b_t ctrl_b_reg;
  sas_pkg::sas_state_t  state_reg;
  sas_pkg::sas_state_t  state_next;
  logic [7:0]           upcfg_reg;
  logic [7:0]           upcfg_mask;
  logic [7:0]           res_hi_reg;
  logic [7:0]           res_lo_reg;
  logic [4:0]           acq_cnt_reg;
  logic [4:0]           acq_len;
  logic [1:0]           wait_cnt_reg;
  logic                 sleep_s1_reg;
  logic                 sleep_s2_reg;
  logic [5:0]           din_s1_reg;
  logic [5:0]           din_s2_reg;
  logic                 tick;
  logic                 wr_a;
  logic                 start_req;
  logic                 go_clear;
  logic                 abort;
  logic                 conv_start;
  logic                 sar_done;
  logic [9:0]           sar_code;
  logic [3:0]           sar_step;
  logic [7:0]           rd_mux;
  logic                 chan_ok;

  // Smaller variant has no pins or channels above eleven
  assign upcfg_mask = PINS80 ? `SAS_UPCFG_MASK : `SAS_UPCFG_MASK64;
  assign chan_ok    = PINS80 || (ctrl_a_reg.channel[3:2] != 2'b11);

  // ****************************************
  // Input synchronisers
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      sleep_s1_reg <= 1'b0;
      sleep_s2_reg <= 1'b0;
      din_s1_reg   <= 6'h00;
      din_s2_reg   <= 6'h00;
    end else begin
      sleep_s1_reg <= sleep_in;
      sleep_s2_reg <= sleep_s1_reg;
      din_s1_reg   <= pin_din_in;
      din_s2_reg   <= din_s1_reg;
    end
  end

  // ****************************************
  // Conversion period and approximation engine
  // ****************************************
  sas_tad_gen u_tad (
    .clk_in    (clk_in),
    .rst_in    (rst_in),
    // Divider restarts on every state change so each phase opens with a full period
    .enable_in (ctrl_a_reg.converter_on && (state_next == state_reg)),
    .sel_in    (ctrl_b_reg.conversion_clock_sel),
    .rc_osc_in (rc_osc_in),
    .sleep_in  (sleep_s2_reg),
    .tick_out  (tick)
  );

  // Comparator follows our registered trial code; two sync flops would outlast a two-clock period
  sas_sar_core u_sar (
    .clk_in   (clk_in),
    .rst_in   (rst_in),
    .start_in (conv_start),
    .abort_in (abort),
    .tick_in  (tick),
    .comp_in  (comp_in),
    .code_out (sar_code),
    .done_out (sar_done),
    .step_out (sar_step)
  );

  // ****************************************
  // Start and abort decode
  // ****************************************
  assign wr_a      = wr_in && (addr_in == `SAS_OFF_CTRL_A);
  // Start only when the module was already on before this write
  assign start_req = wr_a && wdata_in[`SAS_BIT_GO] && ctrl_a_reg.converter_on && !ctrl_a_reg.go;
  assign go_clear  = wr_a && !wdata_in[`SAS_BIT_GO];
  assign abort     = ((state_reg == sas_pkg::SAS_CONV) || (state_reg == sas_pkg::SAS_ACQ))
                     && (go_clear || !ctrl_a_reg.converter_on);

  always_comb begin
    unique case (ctrl_b_reg.acquisition_time_sel)
      3'b000: acq_len = 5'd0;
      3'b001: acq_len = 5'd2;
      3'b010: acq_len = 5'd4;
      3'b011: acq_len = 5'd6;
      3'b100: acq_len = 5'd8;
      3'b101: acq_len = 5'd12;
      3'b110: acq_len = 5'd16;
      3'b111: acq_len = 5'd20;
    endcase
  end

  // ****************************************
  // Sequence state machine
  // ****************************************
  always_comb begin
    state_next = state_reg;
    conv_start = 1'b0;
    unique case (state_reg)
      sas_pkg::SAS_SAMPLE: begin
        if (ctrl_a_reg.go && ctrl_a_reg.converter_on) begin
          if (acq_len == 5'd0) begin
            state_next = sas_pkg::SAS_CONV;
            conv_start = 1'b1;
          end else begin
            state_next = sas_pkg::SAS_ACQ;
          end
        end
      end
      sas_pkg::SAS_ACQ: begin
        if (abort) begin
          state_next = sas_pkg::SAS_SAMPLE;
        end else if (tick && (acq_cnt_reg == acq_len - 5'd1)) begin
          state_next = sas_pkg::SAS_CONV;
          conv_start = 1'b1;
        end
      end
      sas_pkg::SAS_CONV: begin
        if (abort || sar_done) begin
          state_next = sas_pkg::SAS_WAIT;
        end
      end
      sas_pkg::SAS_WAIT: begin
        if (!ctrl_a_reg.converter_on) begin
          state_next = sas_pkg::SAS_SAMPLE;
        end else if (tick && (wait_cnt_reg == `SAS_WAIT_TADS - 2'h1)) begin
          state_next = sas_pkg::SAS_SAMPLE;
        end
      end
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      state_reg <= sas_pkg::SAS_SAMPLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      acq_cnt_reg  <= 5'h00;
      wait_cnt_reg <= 2'h0;
    end else begin
      if (state_reg != sas_pkg::SAS_ACQ) begin
        acq_cnt_reg <= 5'h00;
      end else if (tick) begin
        acq_cnt_reg <= acq_cnt_reg + 5'h01;
      end
      if (state_reg != sas_pkg::SAS_WAIT) begin
        wait_cnt_reg <= 2'h0;
      end else if (tick) begin
        wait_cnt_reg <= wait_cnt_reg + 2'h1;
      end
    end
  end

  // ****************************************
  // Control registers
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      ctrl_a_reg <= `SAS_RST_CTRL_A;
      ctrl_b_reg <= `SAS_RST_CTRL_B;
      upcfg_reg  <= `SAS_RST_UPCFG;
    end else begin
      if (wr_a) begin
        ctrl_a_reg.vref_neg_ext <= wdata_in[7];
        ctrl_a_reg.vref_pos_ext <= wdata_in[6];
        ctrl_a_reg.channel      <= wdata_in[5:2];
        ctrl_a_reg.converter_on <= wdata_in[`SAS_BIT_ON];
      end
      // Completion clears the start bit even if software writes in the same cycle
      if (sar_done && !abort) begin
        ctrl_a_reg.go <= 1'b0;
      end else if (wr_a && (!wdata_in[`SAS_BIT_ON] || !ctrl_a_reg.converter_on)) begin
        ctrl_a_reg.go <= 1'b0;
      end else if (wr_a) begin
        ctrl_a_reg.go <= start_req || (ctrl_a_reg.go && wdata_in[`SAS_BIT_GO]);
      end
      if (wr_in && (addr_in == `SAS_OFF_CTRL_B)) begin
        ctrl_b_reg <= wdata_in;
      end
      if (wr_in && (addr_in == `SAS_OFF_UPCFG)) begin
        upcfg_reg <= wdata_in & upcfg_mask;
      end
    end
  end

  // Done flag: hardware set wins over a software clear in the same cycle
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      done_flag_out <= 1'b0;
      irq_en_out    <= 1'b0;
    end else begin
      if (sar_done && !abort) begin
        done_flag_out <= 1'b1;
      end else if (wr_in && (addr_in == `SAS_OFF_FLAGS)) begin
        done_flag_out <= wdata_in[`SAS_BIT_DONE];
      end
      if (wr_in && (addr_in == `SAS_OFF_FLAGS)) begin
        irq_en_out <= wdata_in[`SAS_BIT_IRQEN];
      end
    end
  end

  // ****************************************
  // Result pair
  // ****************************************
  // No reset here on purpose: the pair survives any reset with its old contents
  always_ff @(posedge clk_in) begin
    if (sar_done && !abort) begin
      if (ctrl_b_reg.right_justify) begin
        res_hi_reg <= {6'h00, sar_code[9:8]};
        res_lo_reg <= sar_code[7:0];
      end else begin
        res_hi_reg <= sar_code[9:2];
        res_lo_reg <= {sar_code[1:0], 6'h00};
      end
    end else if (wr_in && (addr_in == `SAS_OFF_RES_HI)) begin
      res_hi_reg <= wdata_in;
    end else if (wr_in && (addr_in == `SAS_OFF_RES_LO)) begin
      res_lo_reg <= wdata_in;
    end
  end

  // ****************************************
  // Read port
  // ****************************************
  always_comb begin
    unique case (addr_in)
      `SAS_OFF_CTRL_A: rd_mux = ctrl_a_reg;
      `SAS_OFF_CTRL_B: rd_mux = ctrl_b_reg;
      `SAS_OFF_UPCFG:  rd_mux = upcfg_reg & upcfg_mask;
      `SAS_OFF_RES_HI: rd_mux = res_hi_reg;
      `SAS_OFF_RES_LO: rd_mux = res_lo_reg;
      `SAS_OFF_FLAGS:  rd_mux = {6'h00, irq_en_out, done_flag_out};
      default:         rd_mux = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      rdata_out <= 8'h00;
    end else if (rd_in) begin
      rdata_out <= rd_mux;
    end else begin
      rdata_out <= 8'h00;
    end
  end

  // ****************************************
  // Pins and analog front end
  // ****************************************
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pin_dig_out <= 6'h00;
      pin_ana_out <= 6'h3f;
      analog_out  <= '0;
    end else begin
      pin_dig_out <= din_s2_reg & upcfg_reg[7:2];
      pin_ana_out <= ~upcfg_reg[7:2];
      analog_out.vref_pos_ext <= ctrl_a_reg.vref_pos_ext;
      analog_out.vref_neg_ext <= ctrl_a_reg.vref_neg_ext;
      analog_out.channel      <= ctrl_a_reg.channel;
      analog_out.trial_code   <= sar_code;
      // Capacitor tracks the pin only while sampling or acquiring
      analog_out.hold_connect <= ctrl_a_reg.converter_on && chan_ok
                                 && ((state_next == sas_pkg::SAS_SAMPLE)
                                 || (state_next == sas_pkg::SAS_ACQ));
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  cfg_low_zero_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (rd_in && addr_in == `SAS_OFF_UPCFG) |=> (rdata_out[1:0] == 2'b00))
    else $error("unimplemented config bits read nonzero");

  dig_mask_a: assert property (@(posedge clk_in) disable iff (rst_in)
    1'b1 |=> ((pin_dig_out & ~$past(upcfg_reg[7:2])) == 6'h00))
    else $error("analog pin reads nonzero digitally");

  hold_iso_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == sas_pkg::SAS_CONV) |-> !analog_out.hold_connect)
    else $error("holding capacitor connected during conversion");

  done_load_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (sar_done && !abort) |=> (done_flag_out && !ctrl_a_reg.go && state_reg == sas_pkg::SAS_WAIT))
    else $error("completion did not raise flag and clear start");

  zero_acq_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == sas_pkg::SAS_SAMPLE && ctrl_a_reg.go && ctrl_a_reg.converter_on && acq_len == 5'd0)
    |=> (state_reg == sas_pkg::SAS_CONV))
    else $error("zero acquisition did not convert at once");

  conv_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
    sar_done |-> ($past(sar_step) == 4'ha))
    else $error("conversion not eleven periods");

  abort_keep_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == sas_pkg::SAS_CONV && go_clear) |=> (!done_flag_out || $past(done_flag_out)))
    else $error("aborted conversion raised done flag");

  rest_wait_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == sas_pkg::SAS_WAIT && ctrl_a_reg.converter_on && state_next == sas_pkg::SAS_SAMPLE)
    |-> (wait_cnt_reg == 2'h1 && tick))
    else $error("left rest before two periods");

  acq_len_a: assert property (@(posedge clk_in) disable iff (rst_in)
    (state_reg == sas_pkg::SAS_ACQ && state_next == sas_pkg::SAS_CONV) |-> (acq_cnt_reg + 5'd1 == acq_len))
    else $error("acquisition length wrong");

  off_idle_a: assert property (@(posedge clk_in) disable iff (rst_in)
    !ctrl_a_reg.converter_on |=> !ctrl_a_reg.go)
    else $error("start bit set while module off");
endmodule
`default_nettype wire

//--- sim/sas_comp_model.sv
// Sample-and-hold and comparator model facing the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sas_comp_model (
  input  wire logic                 clk_in,     // System clock
  input  wire sas_pkg::sas_analog_t analog_in,  // Front-end controls
  input  wire logic [9:0]           level_in,   // Level on the selected pin
  output logic                      comp_out    // 1 = held level at or above trial
);
  logic [9:0] held_reg;

  // Pin changes after the switch opens must not reach the decision
  always_ff @(posedge clk_in) begin
    if (analog_in.hold_connect) begin
      held_reg <= level_in;
    end
  end

  assign comp_out = (held_reg >= analog_in.trial_code);
endmodule
`default_nettype wire

//--- sim/sas_sequencer_bench.sv
// Self-checking bench for the converter sequencer
`timescale 1ns/1ns
`default_nettype none
module sas_sequencer_bench;
  logic                 clk_in = 1'b0;
  logic                 rst_in = 1'b1;
  logic                 wr_in = 1'b0;
  logic                 rd_in = 1'b0;
  logic                 comp;
  logic                 sleep = 1'b0;
  logic [2:0]           addr_in = 3'h0;
  logic [7:0]           wdata_in = 8'h00;
  logic [7:0]           rdata_out;
  logic [7:0]           d;
  logic [5:0]           pin_din_in = 6'h2d;
  logic [5:0]           pin_dig_out;
  logic [5:0]           pin_ana_out;
  logic [9:0]           level = 10'h2b5;
  sas_pkg::sas_analog_t analog_out;
  logic                 done_flag_out;
  logic                 irq_en_out;
  int                   failures = 0;
  int                   check_count = 0;
  int                   cyc = 0;
  int                   t0;
  int                   acq_tab[8] = '{0, 2, 4, 6, 8, 12, 16, 20};
  int                   clk_tab[6] = '{0, 1, 2, 4, 5, 6};
  int                   div_tab[6] = '{2, 8, 32, 4, 16, 64};

  always #50 clk_in = ~clk_in;
  always @(posedge clk_in) cyc++;

  sas_sequencer sas_sequencer_i (.clk_in, .rst_in, .addr_in, .wdata_in, .wr_in, .rd_in, .rdata_out,
    .rc_osc_in(1'b0), .sleep_in(sleep), .comp_in(comp), .pin_din_in, .pin_dig_out, .pin_ana_out,
    .analog_out, .done_flag_out, .irq_en_out);
  sas_comp_model sas_comp_model_i (.clk_in, .analog_in(analog_out), .level_in(level), .comp_out(comp));

  task automatic give_verdict;
    if (failures == 0 && check_count > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  task automatic cmp(input string what, input logic [7:0] exp, input logic [7:0] got);
    check_count++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(input logic [2:0] a, input logic [7:0] v);
    @(posedge clk_in);
    addr_in <= a;
    wdata_in <= v;
    wr_in <= 1'b1;
    @(posedge clk_in);
    wr_in <= 1'b0;
  endtask

  task automatic rd(input logic [2:0] a);
    @(posedge clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge clk_in);
    rd_in <= 1'b0;
    #1 d = rdata_out;
  endtask

  // Right justified result of the fixed level, then wait until sampling resumes
  task automatic conv(input logic [7:0] b, input int p, input int a);
    wr(3'h1, b);
    wr(3'h5, 8'h02);
    wr(3'h0, 8'h03);
    t0 = cyc;
    d = 8'h02;
    while (d[1] && cyc - t0 < 2000) rd(3'h0);
    cmp("duration", 8'h01, {7'h0, (cyc - t0 >= (a + 11) * p - p) && (cyc - t0 <= (a + 11) * p + p + 6)});
    cmp("control a", 8'h01, d);
    rd(3'h3);
    cmp("result high", 8'h02, d);
    rd(3'h4);
    cmp("result low", 8'hb5, d);
    rd(3'h5);
    cmp("flags", 8'h03, d);
    for (int i = 0; i < 300 && !analog_out.hold_connect; i++) @(posedge clk_in);
    cmp("hold after", 8'h01, {7'h0, analog_out.hold_connect});
  endtask

  initial begin
    #3_000_000;
    failures++;
    give_verdict;
  end

  initial begin
    repeat (20) @(posedge clk_in);
    rst_in <= 1'b0;
    rd(3'h2);
    cmp("upper config", 8'h00, d);
    cmp("analog pins", 8'h3f, {2'h0, pin_ana_out});
    wr(3'h2, 8'hff);
    rd(3'h2);
    cmp("upper config", 8'hfc, d);
    repeat (4) @(posedge clk_in);
    cmp("digital reads", 8'h2d, {2'h0, pin_dig_out});
    wr(3'h2, 8'h14);
    repeat (4) @(posedge clk_in);
    cmp("digital reads", 8'h05, {2'h0, pin_dig_out});
    cmp("analog pins", 8'h3a, {2'h0, pin_ana_out});
    rd(3'h6);
    cmp("unmapped", 8'h00, d);
    wr(3'h0, 8'h01);
    for (int i = 0; i < 8; i++) conv({2'b10, i[2:0], 3'b001}, 8, acq_tab[i]);
    for (int i = 0; i < 6; i++) conv({5'b10000, clk_tab[i][2:0]}, div_tab[i], 0);
    // Sleep freezes divided periods: start bit stays up until sleep ends
    wr(3'h5, 8'h00);
    wr(3'h1, 8'h80);
    sleep <= 1'b1;
    wr(3'h0, 8'h03);
    repeat (100) @(posedge clk_in);
    rd(3'h0);
    cmp("control a", 8'h03, d);
    sleep <= 1'b0;
    repeat (60) @(posedge clk_in);
    rd(3'h5);
    cmp("flags", 8'h01, d);
    // Abort on the slowest divider so the cut lands well inside the conversion
    wr(3'h1, 8'h86);
    wr(3'h5, 8'h00);
    level = 10'h155;
    wr(3'h0, 8'h03);
    repeat (300) @(posedge clk_in);
    wr(3'h0, 8'h01);
    repeat (20) @(posedge clk_in);
    rd(3'h4);
    cmp("result low", 8'hb5, d);
    cmp("done flag", 8'h00, {7'h0, done_flag_out});
    wr(3'h0, 8'hf3);
    repeat (10) @(posedge clk_in);
    cmp("references", 8'h3c, {2'h0, analog_out.vref_neg_ext, analog_out.vref_pos_ext, analog_out.channel});
    rst_in <= 1'b1;
    @(posedge clk_in);
    rst_in <= 1'b0;
    rd(3'h0);
    cmp("control a", 8'h00, d);
    rd(3'h4);
    cmp("result low", 8'hb5, d);
    give_verdict;
  end
endmodule
`default_nettype wire
